// ---- verilog/lcd_cmd_pkg.sv ----
`default_nettype none
package lcd_cmd_pkg;
    // Field sizes of the serial frames, RAM depth and synchroniser width.
    localparam int ADDR_BITS = 6;
    localparam int NIB_BITS = 4;
    localparam int RAM_DEPTH = 32;
    localparam int SYNC_WIDTH = 4;

    // Mode identifiers, first bit sent in bit 2.
    localparam logic [2:0] ID_READ = 3'h6;
    localparam logic [2:0] ID_WRITE = 3'h5;
    localparam logic [2:0] ID_CMD = 3'h4;

    // Bit counts minus one for each frame field.
    localparam logic [3:0] CNT_ID_LAST = 4'h2;
    localparam logic [3:0] CNT_ADDR_LAST = 4'h5;
    localparam logic [3:0] CNT_NIB_LAST = 4'h3;
    localparam logic [3:0] CNT_CMD_LAST = 4'h8;
    localparam logic [1:0] RD_CNT_LAST = 2'h3;

    // Synchroniser reset: chip select and both strobes idle high, data low.
    localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 4'he;

    typedef enum logic [2:0] {
        ST_ID = 3'h0,
        ST_ADDR = 3'h1,
        ST_DATA = 3'h3,
        ST_CMD = 3'h2,
        ST_HALT = 3'h6
    } ser_state_t;

    typedef enum logic [1:0] {
        CLK_NONE = 2'h0,
        CLK_CRYSTAL = 2'h1,
        CLK_INTERNAL = 2'h2,
        CLK_EXTERNAL = 2'h3
    } clk_src_t;

    // Values after reset.
    localparam logic [2:0] RST_RATE = 3'h7;
    localparam logic [1:0] RST_COMMONS = 2'h0;
    localparam logic RST_BIAS_THIRD = 1'b0;
    localparam logic RST_LOW_PITCH = 1'b0;
endpackage
`default_nettype wire

// ---- verilog/lcd_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcd_pin_sync #(
    parameter int WIDTH = lcd_cmd_pkg::SYNC_WIDTH,
    parameter logic [WIDTH-1:0] RESET_VALUE = lcd_cmd_pkg::SYNC_RESET
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic resetn_in,
    // Pin levels in and out.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            stage1_q <= RESET_VALUE;
            stage2_q <= RESET_VALUE;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;
endmodule
`default_nettype wire

// ---- verilog/lcd_two_entry_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcd_two_entry_buf #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic resetn_in,
    // Filling side.
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Draining side.
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] slot_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic push;
    logic pop;

    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] ptr);
        if (int'(ptr) == DEPTH - 1) begin
            return '0;
        end
        return ptr + PTR_W'(1);
    endfunction

    assign in_ready_out = (int'(count_q) < DEPTH);
    assign out_valid_out = (count_q != '0);
    assign out_data_out = slot_q[rd_ptr_q];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clock_in) begin
        if (push) begin
            slot_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= bump(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= bump(rd_ptr_q);
            end
            if (push && !pop) begin
                count_q <= count_q + CNT_W'(1);
            end else if (pop && !push) begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ---- verilog/lcd_cmd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_decoder #(
    parameter int RAM_DEPTH = lcd_cmd_pkg::RAM_DEPTH
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic resetn_in,
    // Serial pins from the host.
    input wire logic select_n_in,
    input wire logic write_strobe_n_in,
    input wire logic read_strobe_n_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n_out,
    // Panel scan read port and RAM write back-pressure.
    input wire logic [$clog2(RAM_DEPTH)-1:0] scan_index_in,
    output logic [3:0] scan_nibble_out,
    input wire logic ram_write_stall_in,
    output logic write_ready_out,
    // Configuration state.
    output logic osc_on_out,
    output logic bias_on_out,
    output logic buzzer_on_out,
    output logic buzzer_low_pitch_out,
    output logic timebase_out_en_out,
    output logic watchdog_flag_en_out,
    output logic flag_pin_en_out,
    output logic bias_third_out,
    output logic test_mode_out,
    output logic [1:0] clock_src_out,
    output logic [1:0] commons_out,
    output logic [2:0] rate_sel_out,
    // One-cycle clear pulses.
    output logic timebase_clear_out,
    output logic watchdog_clear_out
);
    localparam int IDX_W = $clog2(RAM_DEPTH);
    localparam int AW = lcd_cmd_pkg::ADDR_BITS;

    logic [3:0] pins_s;
    logic prev_wr_q;
    logic prev_rd_q;
    logic cs_high;
    logic bit_s;
    logic wr_rise;
    logic rd_fall;
    lcd_cmd_pkg::ser_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic read_mode_q;
    logic [AW-1:0] addr_q;
    logic [3:0] wnib_q;
    logic [3:0] rnib_q;
    logic [1:0] rd_cnt_q;
    logic drive_q;
    logic data_q;
    logic [3:0] ram_q [RAM_DEPTH];
    logic [2:0] id_word;
    logic [AW-1:0] addr_word;
    logic [8:0] cmd_word;
    logic [3:0] nib_word;
    logic cmd_fire;
    logic nib_done;
    logic addr_done;
    logic rd_step;
    logic buf_valid;
    logic [IDX_W+3:0] buf_data;

    function automatic logic [IDX_W-1:0] ram_index(input logic [AW-1:0] a);
        return a[IDX_W-1:0];
    endfunction

    function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
        return a + AW'(1);
    endfunction

    // Every pin passes two flip-flops; edges are found on the synchronised copies only.
    lcd_pin_sync #(
        .WIDTH(lcd_cmd_pkg::SYNC_WIDTH),
        .RESET_VALUE(lcd_cmd_pkg::SYNC_RESET)
    ) u_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .async_in({select_n_in, write_strobe_n_in, read_strobe_n_in, serial_data_in}),
        .sync_out(pins_s)
    );

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            prev_wr_q <= 1'b1;
            prev_rd_q <= 1'b1;
        end else begin
            prev_wr_q <= pins_s[2];
            prev_rd_q <= pins_s[1];
        end
    end

    assign cs_high = pins_s[3];
    assign bit_s = pins_s[0];
    assign wr_rise = pins_s[2] && !prev_wr_q && !cs_high;
    assign rd_fall = !pins_s[1] && prev_rd_q && !cs_high;
    assign id_word = {shift_q[1:0], bit_s};
    assign addr_word = {shift_q[4:0], bit_s};
    assign cmd_word = {shift_q[7:0], bit_s};
    assign nib_word = {bit_s, wnib_q[3:1]};
    assign cmd_fire = wr_rise && state_q == lcd_cmd_pkg::ST_CMD && cnt_q == lcd_cmd_pkg::CNT_CMD_LAST;
    assign addr_done = wr_rise && state_q == lcd_cmd_pkg::ST_ADDR && cnt_q == lcd_cmd_pkg::CNT_ADDR_LAST;
    assign nib_done = wr_rise && state_q == lcd_cmd_pkg::ST_DATA && !read_mode_q
        && cnt_q == lcd_cmd_pkg::CNT_NIB_LAST;
    assign rd_step = rd_fall && state_q == lcd_cmd_pkg::ST_DATA;

    // Frame sequencer: identifier, then address and nibbles or a run of commands.
    always_ff @(posedge clock_in) begin
        if (!resetn_in || cs_high) begin
            state_q <= lcd_cmd_pkg::ST_ID;
            cnt_q <= 4'h0;
        end else if (wr_rise) begin
            cnt_q <= cnt_q + 4'h1;
            case (state_q)
                lcd_cmd_pkg::ST_ID: begin
                    if (cnt_q == lcd_cmd_pkg::CNT_ID_LAST) begin
                        cnt_q <= 4'h0;
                        if (id_word == lcd_cmd_pkg::ID_READ || id_word == lcd_cmd_pkg::ID_WRITE) begin
                            state_q <= lcd_cmd_pkg::ST_ADDR;
                        end else if (id_word == lcd_cmd_pkg::ID_CMD) begin
                            state_q <= lcd_cmd_pkg::ST_CMD;
                        end else begin
                            state_q <= lcd_cmd_pkg::ST_HALT;
                        end
                    end
                end
                lcd_cmd_pkg::ST_ADDR: begin
                    if (addr_done) begin
                        cnt_q <= 4'h0;
                        state_q <= lcd_cmd_pkg::ST_DATA;
                    end
                end
                lcd_cmd_pkg::ST_DATA: begin
                    if (cnt_q == lcd_cmd_pkg::CNT_NIB_LAST) begin
                        cnt_q <= 4'h0;
                    end
                end
                lcd_cmd_pkg::ST_CMD: begin
                    if (cmd_fire) begin
                        cnt_q <= 4'h0;
                    end
                end
                default: begin
                    cnt_q <= 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            shift_q <= 8'h00;
            read_mode_q <= 1'b0;
            wnib_q <= 4'h0;
        end else if (wr_rise) begin
            shift_q <= {shift_q[6:0], bit_s};
            if (state_q == lcd_cmd_pkg::ST_ID && cnt_q == lcd_cmd_pkg::CNT_ID_LAST) begin
                read_mode_q <= (id_word == lcd_cmd_pkg::ID_READ);
            end
            if (state_q == lcd_cmd_pkg::ST_DATA) begin
                wnib_q <= nib_word;
            end
        end
    end

    // Address pointer, loaded MSB first and advanced after each written nibble and, in read mode only, each read nibble.
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            addr_q <= '0;
        end else if (addr_done) begin
            addr_q <= addr_word;
        end else if (nib_done || (rd_step && read_mode_q && rd_cnt_q == lcd_cmd_pkg::RD_CNT_LAST)) begin
            addr_q <= next_addr(addr_q);
        end
    end

    // Outgoing nibble, shifted out bit 0 first on read strobe falls.
    always_ff @(posedge clock_in) begin
        if (!resetn_in || cs_high) begin
            rnib_q <= 4'h0;
            rd_cnt_q <= 2'h0;
            data_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            if (addr_done) begin
                rnib_q <= ram_q[ram_index(addr_word)];
                rd_cnt_q <= 2'h0;
            end else if (nib_done) begin
                rnib_q <= ram_q[ram_index(next_addr(addr_q))];
                rd_cnt_q <= 2'h0;
            end else if (rd_step) begin
                rd_cnt_q <= rd_cnt_q + 2'h1;
                if (read_mode_q && rd_cnt_q == lcd_cmd_pkg::RD_CNT_LAST) begin
                    rnib_q <= ram_q[ram_index(next_addr(addr_q))];
                end else begin
                    rnib_q <= {1'b0, rnib_q[3:1]};
                end
            end
            if (rd_step) begin
                data_q <= rnib_q[0];
                drive_q <= 1'b1;
            end else if (wr_rise || state_q != lcd_cmd_pkg::ST_DATA) begin
                drive_q <= 1'b0;
            end
        end
    end

    assign serial_data_out = data_q;
    assign serial_data_oe_n_out = !drive_q;

    // Completed nibbles wait here while the panel scan holds the RAM write port.
    lcd_two_entry_buf #(
        .WIDTH(IDX_W + 4),
        .DEPTH(2)
    ) u_buf (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .in_valid_in(nib_done),
        .in_ready_out(write_ready_out),
        .in_data_in({ram_index(addr_q), nib_word}),
        .out_valid_out(buf_valid),
        .out_ready_in(!ram_write_stall_in),
        .out_data_out(buf_data)
    );

    always_ff @(posedge clock_in) begin
        if (buf_valid && !ram_write_stall_in) begin
            ram_q[buf_data[IDX_W+3:4]] <= buf_data[3:0];
        end
    end

    always_ff @(posedge clock_in) begin
        scan_nibble_out <= ram_q[scan_index_in];
    end

    // Configuration commands; the final don't-care bit is never looked at.
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            osc_on_out <= 1'b0;
            bias_on_out <= 1'b0;
            buzzer_on_out <= 1'b0;
            clock_src_out <= lcd_cmd_pkg::CLK_INTERNAL;
            flag_pin_en_out <= 1'b0;
            rate_sel_out <= lcd_cmd_pkg::RST_RATE;
            test_mode_out <= 1'b0;
            timebase_out_en_out <= 1'b0;
            watchdog_flag_en_out <= 1'b0;
            bias_third_out <= lcd_cmd_pkg::RST_BIAS_THIRD;
            commons_out <= lcd_cmd_pkg::RST_COMMONS;
            buzzer_low_pitch_out <= lcd_cmd_pkg::RST_LOW_PITCH;
        end else if (cmd_fire) begin
            casez (cmd_word[8:1])
                8'b0000_0000: begin
                    // An external clock keeps running, so power down is refused then.
                    if (clock_src_out != lcd_cmd_pkg::CLK_EXTERNAL) begin
                        osc_on_out <= 1'b0;
                        bias_on_out <= 1'b0;
                    end
                end
                8'b0000_0001: osc_on_out <= 1'b1;
                8'b0000_0010: bias_on_out <= 1'b0;
                8'b0000_0011: bias_on_out <= 1'b1;
                8'b0000_0100: timebase_out_en_out <= 1'b0;
                8'b0000_0110: timebase_out_en_out <= 1'b1;
                8'b0000_0101: watchdog_flag_en_out <= 1'b0;
                8'b0000_0111: watchdog_flag_en_out <= 1'b1;
                8'b0000_1000: buzzer_on_out <= 1'b0;
                8'b0000_1001: buzzer_on_out <= 1'b1;
                8'b0001_01??: clock_src_out <= lcd_cmd_pkg::CLK_CRYSTAL;
                8'b0001_10??: clock_src_out <= lcd_cmd_pkg::CLK_INTERNAL;
                8'b0001_11??: clock_src_out <= lcd_cmd_pkg::CLK_EXTERNAL;
                8'b0010_????: begin
                    bias_third_out <= cmd_word[1];
                    if (cmd_word[4:3] != 2'h3) begin
                        commons_out <= cmd_word[4:3];
                    end
                end
                8'b010?_????: buzzer_low_pitch_out <= 1'b0;
                8'b011?_????: buzzer_low_pitch_out <= 1'b1;
                8'b100?_????: flag_pin_en_out <= cmd_word[4];
                8'b101?_????: rate_sel_out <= cmd_word[3:1];
                8'b1110_0000: test_mode_out <= 1'b1;
                8'b1110_0011: test_mode_out <= 1'b0;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            timebase_clear_out <= 1'b0;
            watchdog_clear_out <= 1'b0;
        end else begin
            timebase_clear_out <= cmd_fire && cmd_word[8:3] == 6'h03;
            watchdog_clear_out <= cmd_fire && cmd_word[8:2] == 7'h07;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    sequence s_clear_pulse;
        timebase_clear_out ##1 !timebase_clear_out;
    endsequence

    a_cs_abort: assert property (cs_high |=> state_q == lcd_cmd_pkg::ST_ID && cnt_q == 4'h0)
        else $error("chip select high did not reset the frame");
    a_stop_all: assert property (cmd_fire && cmd_word[8:1] == 8'h00
        && clock_src_out != lcd_cmd_pkg::CLK_EXTERNAL |=> !osc_on_out && !bias_on_out)
        else $error("stop command left oscillator or bias on");
    a_osc_start: assert property (cmd_fire && cmd_word[8:1] == 8'h01 |=> osc_on_out)
        else $error("start command did not start the oscillator");
    a_bias_on: assert property (cmd_fire && cmd_word[8:1] == 8'h03 |=> bias_on_out && $changed(cnt_q))
        else $error("bias on command not applied");
    a_tb_clear: assert property (cmd_fire && cmd_word[8:3] == 6'h03 |=> s_clear_pulse)
        else $error("time base clear pulse wrong");
    a_wd_clear: assert property (cmd_fire && cmd_word[8:2] == 7'h07
        |=> watchdog_clear_out && timebase_clear_out) else $error("watchdog clear pulse missing");
    a_rate_set: assert property (cmd_fire && cmd_word[8:6] == 3'h5
        |=> rate_sel_out == $past(cmd_word[3:1])) else $error("rate field not taken");
    a_cmd_repeat: assert property (cmd_fire && !pins_s[3]
        |=> state_q == lcd_cmd_pkg::ST_CMD && cnt_q == 4'h0) else $error("command run did not continue");
    a_read_bit: assert property (rd_step |=> !serial_data_oe_n_out && serial_data_out == $past(rnib_q[0]))
        else $error("read bit not driven");
    a_reset_vals: assert property (disable iff (1'b0) !resetn_in |=> !osc_on_out && !flag_pin_en_out
        && rate_sel_out == lcd_cmd_pkg::RST_RATE && !test_mode_out) else $error("reset defaults wrong");
endmodule
`default_nettype wire

// ---- tb/lcd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
    // Clock.
    input wire logic clock_in,
    // Device side of the data pin.
    input wire logic dev_data_in,
    input wire logic dev_oe_n_in,
    // Pins toward the device.
    output logic select_n_out,
    output logic write_strobe_n_out,
    output logic read_strobe_n_out,
    output logic line_out
);
    logic drive_q;
    logic bit_q;
    logic last_q;

    initial begin
        select_n_out = 1'b1;
        write_strobe_n_out = 1'b1;
        read_strobe_n_out = 1'b1;
        drive_q = 1'b1;
        bit_q = 1'b0;
    end

    // A released line floats, so it shows the inverse of its last level to keep stale bits from passing.
    assign line_out = drive_q ? bit_q : (!dev_oe_n_in ? dev_data_in : ~last_q);

    always_ff @(posedge clock_in) begin
        last_q <= line_out;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic select(input logic level);
        @(posedge clock_in);
        select_n_out <= level;
        drive_q <= 1'b1;
        idle(6);
    endtask

    // Every strobe level is held at least five cycles, three more than the two synchroniser stages need.
    task automatic wr_bits(input logic [8:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clock_in);
            bit_q <= v[i];
            drive_q <= 1'b1;
            write_strobe_n_out <= 1'b0;
            idle(5);
            write_strobe_n_out <= 1'b1;
            idle(5);
        end
    endtask

    task automatic rd_nib(output logic [3:0] d);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_in);
            drive_q <= 1'b0;
            read_strobe_n_out <= 1'b0;
            idle(5);
            read_strobe_n_out <= 1'b1;
            idle(5);
            d[i] = line_out;
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock_in, resetn_in, ram_write_stall_in;
    logic [4:0] scan_index_in;
    logic [3:0] rd;
    wire logic cs_n, wr_n, rd_n, line, dout, oe_n, ready, tb_clr, wd_clr;
    wire logic [3:0] scan_nib;
    wire logic [15:0] cfg;
    wire logic osc_on, bias_on, buzz_on, low_pitch, tb_en, wd_en, flag_en, bias_third, test_mode;
    wire logic [1:0] clk_src, commons;
    wire logic [2:0] rate;
    assign cfg = {osc_on, bias_on, buzz_on, low_pitch, tb_en, wd_en, flag_en, bias_third, test_mode, clk_src, commons, rate};
    int errors = 0, n_tests = 0, tb_clrs = 0, wd_clrs = 0;
    // The check mode code is never sent; only the regular mode code is.
    logic [7:0] cmd_tab [29] = '{8'h01, 8'h03, 8'h02, 8'h03, 8'h00, 8'h06, 8'h04, 8'h07, 8'h05, 8'h09, 8'h08,
        8'h0c, 8'h0e, 8'h14, 8'h1c, 8'h01, 8'h00, 8'h18, 8'h2b, 8'h24, 8'h2c, 8'h60, 8'h40, 8'h88, 8'h80,
        8'ha0, 8'ha3, 8'ha7, 8'he3};
    logic [15:0] cfg_tab [29] = '{16'h8047, 16'hc047, 16'h8047, 16'hc047, 16'h0047, 16'h0847, 16'h0047,
        16'h0447, 16'h0047, 16'h2047, 16'h0047, 16'h0047, 16'h0047, 16'h0027, 16'h0067, 16'h8067, 16'h8067,
        16'h8047, 16'h8157, 16'h804f, 16'h804f, 16'h904f, 16'h804f, 16'h824f, 16'h804f, 16'h8048, 16'h804b,
        16'h804f, 16'h804f};

    lcd_host_model u_host (.clock_in(clock_in), .dev_data_in(dout), .dev_oe_n_in(oe_n), .select_n_out(cs_n),
        .write_strobe_n_out(wr_n), .read_strobe_n_out(rd_n), .line_out(line));

    lcd_cmd_decoder u_dut (.clock_in(clock_in), .resetn_in(resetn_in), .select_n_in(cs_n),
        .write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n), .serial_data_in(line), .serial_data_out(dout),
        .serial_data_oe_n_out(oe_n), .scan_index_in(scan_index_in), .scan_nibble_out(scan_nib),
        .ram_write_stall_in(ram_write_stall_in), .write_ready_out(ready), .osc_on_out(osc_on),
        .bias_on_out(bias_on), .buzzer_on_out(buzz_on), .buzzer_low_pitch_out(low_pitch),
        .timebase_out_en_out(tb_en), .watchdog_flag_en_out(wd_en), .flag_pin_en_out(flag_en),
        .bias_third_out(bias_third), .test_mode_out(test_mode), .clock_src_out(clk_src), .commons_out(commons),
        .rate_sel_out(rate), .timebase_clear_out(tb_clr), .watchdog_clear_out(wd_clr));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // Pulses are counted mid-cycle, where they are settled.
    always @(negedge clock_in) begin
        if (tb_clr === 1'b1) tb_clrs++;
        if (wd_clr === 1'b1) wd_clrs++;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic frame(input logic [2:0] id, input logic [5:0] addr);
        u_host.wr_bits({id, addr}, 9);
    endtask

    task automatic wr_nib(input logic [3:0] d);
        u_host.wr_bits({5'h00, d[0], d[1], d[2], d[3]}, 4);
    endtask

    task automatic scan(input logic [4:0] idx, input logic [3:0] exp);
        @(posedge clock_in);
        scan_index_in <= idx;
        repeat (3) @(posedge clock_in);
        chk(scan_nib, exp);
    endtask

    task automatic run_cmds();
        u_host.select(1'b0);
        u_host.wr_bits({6'h00, lcd_cmd_pkg::ID_CMD}, 3);
        for (int i = 0; i < 29; i++) begin
            u_host.wr_bits({cmd_tab[i], 1'b1}, 9);
            u_host.idle(3);
            chk(cfg, cfg_tab[i]);
        end
        u_host.select(1'b1);
        chk(16'(tb_clrs), 16'h0002);
        chk(16'(wd_clrs), 16'h0001);
    endtask

    task automatic abort_cmd();
        // Seven cut bits cannot line up with the next command, so a missed abort shows up.
        u_host.select(1'b0);
        u_host.wr_bits({2'h0, lcd_cmd_pkg::ID_CMD, 4'h0}, 7);
        u_host.select(1'b1);
        u_host.select(1'b0);
        chk(cfg[13], 1'b0);
        u_host.wr_bits({6'h00, lcd_cmd_pkg::ID_CMD}, 3);
        u_host.wr_bits(9'h012, 9);
        u_host.idle(3);
        chk(cfg[13], 1'b1);
        u_host.select(1'b1);
        u_host.select(1'b0);
        u_host.wr_bits(9'h007, 3);
        u_host.wr_bits(9'h010, 9);
        u_host.idle(3);
        chk(cfg[13], 1'b1);
        u_host.select(1'b1);
    endtask

    task automatic write_read();
        u_host.select(1'b0);
        frame(lcd_cmd_pkg::ID_WRITE, 6'h05);
        wr_nib(4'ha);
        wr_nib(4'h3);
        wr_nib(4'hf);
        u_host.select(1'b1);
        scan(5'h05, 4'ha);
        scan(5'h07, 4'hf);
        u_host.select(1'b0);
        frame(lcd_cmd_pkg::ID_READ, 6'h05);
        for (int i = 0; i < 3; i++) begin
            u_host.rd_nib(rd);
            chk(rd, (i == 0) ? 4'ha : ((i == 1) ? 4'h3 : 4'hf));
        end
        u_host.select(1'b1);
    endtask

    task automatic rmw();
        u_host.select(1'b0);
        frame(lcd_cmd_pkg::ID_WRITE, 6'h06);
        u_host.rd_nib(rd);
        chk(rd, 4'h3);
        wr_nib(4'hc);
        u_host.select(1'b1);
        scan(5'h06, 4'hc);
    endtask

    task automatic stall_buf();
        @(posedge clock_in);
        ram_write_stall_in <= 1'b1;
        u_host.select(1'b0);
        frame(lcd_cmd_pkg::ID_WRITE, 6'h05);
        wr_nib(4'h1);
        wr_nib(4'h2);
        u_host.idle(3);
        chk(ready, 1'b0);
        wr_nib(4'h4);
        @(posedge clock_in);
        ram_write_stall_in <= 1'b0;
        u_host.select(1'b1);
        scan(5'h05, 4'h1);
        scan(5'h06, 4'h2);
        scan(5'h07, 4'hf);
    endtask

    initial begin
        resetn_in = 1'b0;
        ram_write_stall_in = 1'b0;
        scan_index_in = 5'h00;
        repeat (20) @(posedge clock_in);
        resetn_in <= 1'b1;
        @(posedge clock_in);
        @(posedge clock_in);
        chk(cfg, 16'h0047);
        chk({ready, oe_n, tb_clr, wd_clr}, 4'hc);
        run_cmds();
        abort_cmd();
        write_read();
        rmw();
        stall_buf();
        give_verdict();
    end

    initial begin
        repeat (100000) @(posedge clock_in);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
